/* File: core/boot_copy_select_watchdog.sv */
// Boot copy selector with supervisor watchdog and sticky fired flag.
// Assumes all inputs synchronous to CORE_CLK; RST_N is power-on reset.
// Behaviour
// - Power-on selects the primary firmware copy.
// - Watchdog expiry with auto-reboot jumper reboots from backup copy.
// - Without auto-reboot jumper, backup is taken on next manual reset.
// - Primary-only jumper fitted: never switch to backup.
// - Watchdog reboots processor after about one second without a kick.
// - Flag line reads low when fired, high when not.
// - Flag stays latched until clear line goes low then high.
// - Flag survives processor reboots.
// - Further expiries on backup again reboot from backup.
// - Setup request, restore line low or power cycle restore primary.
// - One indicator shows watchdog fired or primary boot source.
// - Separate indicator is lit while the processor reset is asserted.
// - Watchdog starts after power-on or reset; expiry asserts reset.
// - Fallback to backup requests setup settings returned to defaults.
`timescale 1ns/1ps
module boot_copy_select_watchdog #(
  parameter int unsigned WDOG_CYCLES  = boot_sel_pkg::WDOG_CYCLES,
  parameter int unsigned RESET_CYCLES = boot_sel_pkg::RESET_CYCLES
) (
  input  wire logic CORE_CLK,
  input  wire logic RST_N,
  input  wire logic CLK_EN,
  input  wire logic AUTO_REBOOT_JUMPER,
  input  wire logic PRIMARY_ONLY_JUMPER,
  input  wire logic MANUAL_RESET,
  input  wire logic WDOG_KICK,
  input  wire logic WDOG_STOP,
  input  wire logic SETUP_RESTORE_REQ,
  input  wire logic RESTORE_PRIMARY_LINE,
  input  wire logic FLAG_CLEAR_LINE,
  output logic      WATCHDOG_FIRED_FLAG_LINE,
  output logic      BOOT_FROM_BACKUP,
  output logic      CPU_RESET,
  output logic      SETUP_DEFAULTS_REQ,
  output logic      WATCHDOG_BOOT_INDICATOR,
  output logic      HARDWARE_RESET_INDICATOR
);
  localparam logic [boot_sel_pkg::CNT_W-1:0] RST_LOAD =
    (boot_sel_pkg::CNT_W)'(RESET_CYCLES);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic wd_expired;
  logic clr_done;
  logic rst_start;
  logic rst_end_q;
  logic rst_end_d;

  wdog_timer #(
    .TIMEOUT_CYCLES (WDOG_CYCLES)
  ) u_wdog (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ce      (CLK_EN),
    .restart (rst_end_q),
    .kick    (WDOG_KICK),
    .stop    (WDOG_STOP),
    .expired (wd_expired)
  );

  clear_seq u_clr (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .ce    (CLK_EN),
    .line  (FLAG_CLEAR_LINE),
    .done  (clr_done)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic                           backup_q;
  logic                           backup_d;
  logic                           pending_q;
  logic                           pending_d;
  logic                           fired_q;
  logic                           fired_d;
  logic [boot_sel_pkg::CNT_W-1:0] rcnt_q;
  logic [boot_sel_pkg::CNT_W-1:0] rcnt_d;
  logic                           cpu_rst_q;
  logic                           cpu_rst_d;
  logic                           flag_line_q;
  logic                           flag_line_d;
  logic                           defaults_q;
  logic                           defaults_d;
  logic                           hw_ind_q;
  logic                           hw_ind_d;
  logic                           wd_ind_q;
  logic                           wd_ind_d;
  logic                           restore;
  logic                           to_backup;

  // Restore wins over a simultaneous switch: software asked explicitly
  assign restore   = SETUP_RESTORE_REQ || !RESTORE_PRIMARY_LINE;
  assign rst_start = wd_expired || MANUAL_RESET;
  assign to_backup = !PRIMARY_ONLY_JUMPER &&
                     ((wd_expired && AUTO_REBOOT_JUMPER) ||
                      (MANUAL_RESET && pending_q));

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    backup_d   = backup_q;
    pending_d  = pending_q;
    fired_d    = fired_q;
    rcnt_d     = rcnt_q;
    cpu_rst_d  = cpu_rst_q;
    rst_end_d  = 1'b0;
    defaults_d = defaults_q;
    // Fired flag only cleared by sequence; set wins over clear
    if (wd_expired)
      fired_d = 1'b1;
    else if (clr_done)
      fired_d = 1'b0;
    if (wd_expired && !AUTO_REBOOT_JUMPER && !PRIMARY_ONLY_JUMPER)
      pending_d = 1'b1;
    if (restore)
    begin
      backup_d  = boot_sel_pkg::COPY_PRIMARY;
      pending_d = 1'b0;
    end
    else if (to_backup)
    begin
      backup_d   = boot_sel_pkg::COPY_BACKUP;
      pending_d  = 1'b0;
      defaults_d = 1'b1;
    end
    if (SETUP_RESTORE_REQ)
      defaults_d = 1'b0;
    // Reset pulse; a new cause restarts it
    if (rst_start)
    begin
      cpu_rst_d = 1'b1;
      rcnt_d    = RST_LOAD;
    end
    else if (cpu_rst_q)
    begin
      if (rcnt_q <= boot_sel_pkg::CNT_ONE)
      begin
        cpu_rst_d = 1'b0;
        rst_end_d = 1'b1;
        rcnt_d    = boot_sel_pkg::CNT_ZERO;
      end
      else
        rcnt_d = rcnt_q - boot_sel_pkg::CNT_ONE;
    end
    hw_ind_d = cpu_rst_d;
    wd_ind_d = fired_d || (backup_d == boot_sel_pkg::COPY_PRIMARY);
    flag_line_d = fired_d ? boot_sel_pkg::FLAG_FIRED_LVL : boot_sel_pkg::FLAG_IDLE_LVL;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      backup_q   <= boot_sel_pkg::COPY_PRIMARY;
      pending_q  <= 1'b0;
      fired_q    <= 1'b0;
      rcnt_q     <= boot_sel_pkg::CNT_ZERO;
      cpu_rst_q  <= 1'b0;
      rst_end_q  <= 1'b1;
      defaults_q <= 1'b0;
      hw_ind_q   <= 1'b0;
      wd_ind_q   <= 1'b1;
      flag_line_q <= boot_sel_pkg::FLAG_IDLE_LVL;
    end
    else if (CLK_EN)
    begin
      backup_q   <= backup_d;
      pending_q  <= pending_d;
      fired_q    <= fired_d;
      rcnt_q     <= rcnt_d;
      cpu_rst_q  <= cpu_rst_d;
      rst_end_q  <= rst_end_d;
      defaults_q <= defaults_d;
      hw_ind_q   <= hw_ind_d;
      wd_ind_q   <= wd_ind_d;
      flag_line_q <= flag_line_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign WATCHDOG_FIRED_FLAG_LINE = flag_line_q;
  assign BOOT_FROM_BACKUP         = backup_q;
  assign CPU_RESET                = cpu_rst_q;
  assign SETUP_DEFAULTS_REQ       = defaults_q;
  assign WATCHDOG_BOOT_INDICATOR  = wd_ind_q;
  assign HARDWARE_RESET_INDICATOR = hw_ind_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_power_on_primary;
    @(posedge CORE_CLK) $rose(RST_N) |-> BOOT_FROM_BACKUP == 1'b0;
  endproperty
  a_power_on_primary: assert property (p_power_on_primary) else $error("not primary at power-on");

  property p_auto_backup;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && wd_expired && AUTO_REBOOT_JUMPER && !PRIMARY_ONLY_JUMPER && !restore)
      |=> BOOT_FROM_BACKUP && CPU_RESET;
  endproperty
  a_auto_backup: assert property (p_auto_backup) else $error("no auto backup reboot");

  property p_manual_backup;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && MANUAL_RESET && pending_q && !PRIMARY_ONLY_JUMPER && !restore)
      |=> BOOT_FROM_BACKUP;
  endproperty
  a_manual_backup: assert property (p_manual_backup) else $error("manual reset missed backup");

  property p_primary_only;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (PRIMARY_ONLY_JUMPER && !BOOT_FROM_BACKUP) |=> !BOOT_FROM_BACKUP;
  endproperty
  a_primary_only: assert property (p_primary_only) else $error("backup with primary-only");

  property p_flag_line;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && wd_expired) |=> (WATCHDOG_FIRED_FLAG_LINE == 1'b0) && fired_q;
  endproperty
  a_flag_line: assert property (p_flag_line) else $error("flag line not low after fire");

  property p_flag_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (fired_q && !clr_done) |=> fired_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag dropped without clear");

  property p_flag_through_reboot;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (fired_q && CPU_RESET && !clr_done) |=> !WATCHDOG_FIRED_FLAG_LINE;
  endproperty
  a_flag_through_reboot: assert property (p_flag_through_reboot) else $error("flag lost");

  property p_restore;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && restore) |=> !BOOT_FROM_BACKUP;
  endproperty
  a_restore: assert property (p_restore) else $error("restore ignored");

  property p_reset_ind;
    @(posedge CORE_CLK) disable iff (!RST_N)
      HARDWARE_RESET_INDICATOR == CPU_RESET;
  endproperty
  a_reset_ind: assert property (p_reset_ind) else $error("reset indicator mismatch");

  property p_wd_reset;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && wd_expired) |=> CPU_RESET;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("expiry without reset");

  property p_stable_sel;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!restore && !to_backup) |=> $stable(BOOT_FROM_BACKUP);
  endproperty
  a_stable_sel: assert property (p_stable_sel) else $error("selection moved");

  property p_clear_flag;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && clr_done && !wd_expired) |=> WATCHDOG_FIRED_FLAG_LINE;
  endproperty
  a_clear_flag: assert property (p_clear_flag) else $error("flag not cleared");

  property p_defaults;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CLK_EN && to_backup && !restore) |=> SETUP_DEFAULTS_REQ;
  endproperty
  a_defaults: assert property (p_defaults) else $error("no defaults request");

  property p_wd_ind;
    @(posedge CORE_CLK) disable iff (!RST_N)
      WATCHDOG_BOOT_INDICATOR == (!WATCHDOG_FIRED_FLAG_LINE || !BOOT_FROM_BACKUP);
  endproperty
  a_wd_ind: assert property (p_wd_ind) else $error("boot indicator mismatch");

  property p_freeze;
    @(posedge CORE_CLK) disable iff (!RST_N)
      !CLK_EN |=> $stable(BOOT_FROM_BACKUP) && $stable(CPU_RESET)
                  && $stable(WATCHDOG_FIRED_FLAG_LINE);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");

  // ----------------------------------------------------------------
  // Covers
  // ----------------------------------------------------------------
  c_pending: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(pending_q));
  c_freeze: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    !CLK_EN && CPU_RESET);
  c_auto: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(BOOT_FROM_BACKUP));
  c_restore: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    $fell(BOOT_FROM_BACKUP));
  c_clear: cover property (@(posedge CORE_CLK) disable iff (!RST_N)
    $rose(WATCHDOG_FIRED_FLAG_LINE));
endmodule // boot_copy_select_watchdog

/* File: core/boot_sel_pkg.sv */
// Constants shared by the boot copy selector and its helpers.
// Assumes a 25 MHz core clock; all pins synchronous to it.
package boot_sel_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 25_000_000;
  localparam int unsigned WDOG_TIMEOUT_MS = 1000;
  localparam int unsigned WDOG_CYCLES     = (CLK_HZ / 1000) * WDOG_TIMEOUT_MS;
  localparam int unsigned RESET_PULSE_US  = 140;
  localparam int unsigned RESET_CYCLES    = (CLK_HZ / 1_000_000) * RESET_PULSE_US;
  localparam int unsigned CNT_W           = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 32'h0000_0001;

  // ----------------------------------------------------------------
  // Boot copy encoding, line levels and clear sequence states
  // ----------------------------------------------------------------
  localparam logic COPY_PRIMARY   = 1'b0;
  localparam logic COPY_BACKUP    = 1'b1;
  localparam logic FLAG_FIRED_LVL = 1'b0;
  localparam logic FLAG_IDLE_LVL  = 1'b1;

  typedef enum logic [2:0] {
    CLR_IDLE = 3'b001,
    CLR_LOW  = 3'b010,
    CLR_DONE = 3'b100
  } clr_state_e;
endpackage

/* File: core/wdog_timer.sv */
// Supervisor watchdog: counts down while running, kick restarts it.
// Assumes kick and stop are one-cycle synchronous strobes.
`timescale 1ns/1ps
module wdog_timer #(
  parameter int unsigned TIMEOUT_CYCLES = boot_sel_pkg::WDOG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic restart,
  input  wire logic kick,
  input  wire logic stop,
  output logic      expired
);
  localparam logic [boot_sel_pkg::CNT_W-1:0] LOAD = (boot_sel_pkg::CNT_W)'(TIMEOUT_CYCLES);

  logic [boot_sel_pkg::CNT_W-1:0] cnt_q;
  logic [boot_sel_pkg::CNT_W-1:0] cnt_d;
  logic                           run_q;
  logic                           run_d;
  logic                           exp_q;
  logic                           exp_d;

  always_comb
  begin
    cnt_d = cnt_q;
    run_d = run_q;
    exp_d = 1'b0;
    if (restart)
    begin
      run_d = 1'b1;
      cnt_d = LOAD;
    end
    else if (stop)
      run_d = 1'b0;
    else if (run_q && kick)
      cnt_d = LOAD;
    else if (run_q && cnt_q == boot_sel_pkg::CNT_ONE)
    begin
      exp_d = 1'b1;
      run_d = 1'b0;
      cnt_d = boot_sel_pkg::CNT_ZERO;
    end
    else if (run_q)
      cnt_d = cnt_q - boot_sel_pkg::CNT_ONE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= boot_sel_pkg::CNT_ZERO;
      run_q <= 1'b0;
      exp_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      run_q <= run_d;
      exp_q <= exp_d;
    end
  end

  assign expired = exp_q;
endmodule // wdog_timer

/* File: core/clear_seq.sv */
// Detects a low-then-high sequence on the flag clear line.
// Assumes the line is synchronous; one-cycle done pulse on the rise.
`timescale 1ns/1ps
module clear_seq (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic line,
  output logic      done
);
  boot_sel_pkg::clr_state_e st_q;
  boot_sel_pkg::clr_state_e st_d;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      boot_sel_pkg::CLR_IDLE: if (!line) st_d = boot_sel_pkg::CLR_LOW;
      boot_sel_pkg::CLR_LOW:  if (line)  st_d = boot_sel_pkg::CLR_DONE;
      boot_sel_pkg::CLR_DONE: st_d = line ? boot_sel_pkg::CLR_IDLE : boot_sel_pkg::CLR_LOW;
      default:                st_d = boot_sel_pkg::CLR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_q <= boot_sel_pkg::CLR_IDLE;
    else if (ce)
      st_q <= st_d;
  end

  assign done = (st_q == boot_sel_pkg::CLR_DONE);
endmodule // clear_seq

/* File: testbench/host_fw_model.sv */
// Host firmware model: kicks the watchdog and runs the flag clear sequence.
// Assumes the bench seeds $urandom once; drives on rising CORE_CLK edges.
`timescale 1ns/1ps
module host_fw_model (
  input  wire logic clk,
  input  wire logic kick_en,
  input  wire logic clr_go,
  output logic      kick,
  output logic      clr_line
);
  int cnt;
  int gap;

  initial
  begin
    kick     = 1'b0;
    clr_line = 1'b1;
    cnt      = 0;
    gap      = 8;
  end

  // Kick gaps stay well inside the shortened timeout
  always @(posedge clk)
  begin
    if (kick_en && cnt >= gap)
    begin
      kick <= 1'b1;
      cnt  <= 0;
      gap  <= $urandom_range(3, 30);
    end
    else
    begin
      kick <= 1'b0;
      cnt  <= kick_en ? cnt + 1 : 0;
    end
  end

  // Low for one cycle, then back high
  always @(posedge clk)
  begin
    if (clr_go && clr_line)
      clr_line <= 1'b0;
    else if (!clr_line)
      clr_line <= 1'b1;
  end
endmodule // host_fw_model

/* File: testbench/tb_boot_copy_select_watchdog.sv */
// Self-checking bench for the boot copy selector.
// Assumes host_fw_model alongside; short watchdog and reset counts.
`timescale 1ns/1ps
module tb_boot_copy_select_watchdog;
  logic clk = 1'b0, rst_n = 1'b0, auto_j = 1'b1, prim_j = 1'b0;
  logic man = 1'b0, stop = 1'b0, setup_req = 1'b0, restore_n = 1'b1;
  logic kick_en = 1'b0, clr_go = 1'b0, ce = 1'b1, seen;
  logic kick, clr_line, flag, backup, cpu_rst, defaults, wd_ind, hw_ind;
  int   num_errors = 0, checks_done = 0, cyc = 0, i;
  localparam int P_CLR = 0, P_SETUP = 1, P_STOP = 2, P_MAN = 3;

  always #20 clk = ~clk;

  host_fw_model fw (.clk(clk), .kick_en(kick_en), .clr_go(clr_go), .kick(kick),
                    .clr_line(clr_line));

  boot_copy_select_watchdog #(.WDOG_CYCLES(50), .RESET_CYCLES(4)) uut (
    .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce), .AUTO_REBOOT_JUMPER(auto_j),
    .PRIMARY_ONLY_JUMPER(prim_j), .MANUAL_RESET(man), .WDOG_KICK(kick),
    .WDOG_STOP(stop), .SETUP_RESTORE_REQ(setup_req), .RESTORE_PRIMARY_LINE(restore_n),
    .FLAG_CLEAR_LINE(clr_line), .WATCHDOG_FIRED_FLAG_LINE(flag),
    .BOOT_FROM_BACKUP(backup), .CPU_RESET(cpu_rst), .SETUP_DEFAULTS_REQ(defaults),
    .WATCHDOG_BOOT_INDICATOR(wd_ind), .HARDWARE_RESET_INDICATOR(hw_ind));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic end_sim();
    $display("Checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic exp, input logic got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Bounded wait for the processor reset level
  task automatic wait_rst(input logic lvl);
    for (i = 0; i < 300 && cpu_rst !== lvl; i++)
      @(negedge clk);
    chk("cpu_reset_wait", lvl, cpu_rst);
  endtask

  // Indicator lit when fired or when the primary copy is selected
  function automatic logic exp_ind(input logic fired, input logic on_backup);
    return fired || !on_backup;
  endfunction

  // One-cycle strobe; all strobes drop together at the second edge
  task automatic pulse(input int sel);
    @(posedge clk);
    case (sel)
      P_CLR:   clr_go    <= 1'b1;
      P_SETUP: setup_req <= 1'b1;
      P_STOP:  stop      <= 1'b1;
      default: man       <= 1'b1;
    endcase
    @(posedge clk);
    clr_go    <= 1'b0;
    setup_req <= 1'b0;
    stop      <= 1'b0;
    man       <= 1'b0;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h5ad3));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("backup", 1'b0, backup);
    chk("flag", 1'b1, flag);
    chk("wd_ind", exp_ind(1'b0, 1'b0), wd_ind);
    chk("hw_ind", 1'b0, hw_ind);
    $display("TEST power_on done");
    wait_rst(1'b1);
    chk("backup", 1'b1, backup);
    chk("flag", 1'b0, flag);
    chk("defaults", 1'b1, defaults);
    chk("hw_ind", 1'b1, hw_ind);
    chk("wd_ind", exp_ind(1'b1, 1'b1), wd_ind);
    wait_rst(1'b0);
    wait_rst(1'b1);
    chk("backup", 1'b1, backup);
    chk("flag", 1'b0, flag);
    wait_rst(1'b0);
    kick_en <= 1'b1;
    $display("TEST auto_switch done");
    pulse(P_CLR);
    repeat (5) @(negedge clk);
    chk("flag", 1'b1, flag);
    chk("wd_ind", exp_ind(1'b0, 1'b1), wd_ind);
    @(posedge clk) restore_n <= 1'b0;
    repeat (2) @(posedge clk);
    restore_n <= 1'b1;
    @(negedge clk);
    chk("backup", 1'b0, backup);
    chk("wd_ind", exp_ind(1'b0, 1'b0), wd_ind);
    pulse(P_SETUP);
    @(negedge clk);
    chk("defaults", 1'b0, defaults);
    $display("TEST clear_restore done");
    seen = 1'b0;
    repeat (300) @(negedge clk) seen |= cpu_rst;
    chk("no_reset_kicked", 1'b0, seen);
    pulse(P_STOP);
    kick_en <= 1'b0;
    seen = 1'b0;
    repeat (300) @(negedge clk) seen |= cpu_rst;
    chk("no_reset_stopped", 1'b0, seen);
    @(posedge clk) prim_j <= 1'b1;
    pulse(P_MAN);
    wait_rst(1'b1);
    chk("hw_ind", 1'b1, hw_ind);
    chk("backup", 1'b0, backup);
    wait_rst(1'b0);
    wait_rst(1'b1);
    chk("backup", 1'b0, backup);
    @(posedge clk);
    auto_j <= 1'b0;
    prim_j <= 1'b0;
    $display("TEST kick_stop_primary done");
    wait_rst(1'b0);
    wait_rst(1'b1);
    chk("backup", 1'b0, backup);
    wait_rst(1'b0);
    kick_en <= 1'b1;
    repeat ($urandom_range(2, 20)) @(posedge clk);
    pulse(P_MAN);
    repeat (3) @(negedge clk);
    chk("backup", 1'b1, backup);
    $display("TEST manual_switch done");
    // Enable low: a restore request and the reset countdown must both freeze
    @(posedge clk);
    ce        <= 1'b0;
    restore_n <= 1'b0;
    repeat (3) @(negedge clk);
    chk("backup_frozen", 1'b1, backup);
    chk("cpu_reset_frozen", 1'b1, cpu_rst);
    @(posedge clk);
    restore_n <= 1'b1;
    ce        <= 1'b1;
    $display("TEST freeze done");
    @(posedge clk) rst_n <= 1'b0;
    @(negedge clk);
    chk("backup", 1'b0, backup);
    chk("flag", 1'b1, flag);
    @(posedge clk) rst_n <= 1'b1;
    $display("TEST power_cycle done");
    end_sim();
  end
endmodule // tb_boot_copy_select_watchdog
